/* pkg/dvdp_pkg.sv */
// package: register map, field layout, reset values and timing for the data valid detect block
package dvdp_pkg;
    // =====================================================================
    // register indices (byte address is four times the index)
    localparam logic [3:0]  IDX_CONFIG      = 4'h0;
    localparam logic [3:0]  IDX_ON_DUR      = 4'h4;
    localparam logic [3:0]  IDX_OFF_DUR     = 4'h5;
    localparam logic [3:0]  IDX_WIN_LOWER   = 4'h6;
    localparam logic [3:0]  IDX_WIN_UPPER   = 4'h7;
    localparam logic [3:0]  IDX_STRENGTH    = 4'h8;
    localparam logic [3:0]  IDX_STATUS      = 4'h9;
    // =====================================================================
    // config field positions
    localparam int          CFG_RX_EN_BIT   = 0;
    localparam int          CFG_POLL_EN_BIT = 1;
    localparam int          CFG_CONT_BIT    = 5;
    localparam int          CFG_SINGLE_BIT  = 6;
    localparam logic [7:0]  CFG_RST         = 8'h00;
    // =====================================================================
    // reset values
    localparam logic [15:0] ON_DUR_RST      = 16'hFEBF;
    localparam logic [15:0] OFF_DUR_RST     = 16'hF37F;
    localparam logic [11:0] WIN_LOWER_RST   = 12'h000;
    localparam logic [11:0] WIN_UPPER_RST   = 12'h001;
    localparam logic [5:0]  STRENGTH_RST    = 6'h3F;
    localparam logic [15:0] TIMER_TOP       = 16'hFFFF;
    // =====================================================================
    // timing
    localparam int          CLK_HZ          = 10_000_000;
    localparam int          RC_HZ           = 32_000;
    localparam int          RC_DIV          = CLK_HZ / RC_HZ;
    localparam int          WIN_DIV         = 4;
    localparam int          SEQ_DELAY_US    = 2600;
    localparam int          SEQ_DELAY_CYC   = (SEQ_DELAY_US * (CLK_HZ / 1_000_000) + 0);
    localparam int          CONV_PERIODS    = 3;
    // =====================================================================
    // detection state
    typedef enum logic [2:0] {
        DVDP_IDLE = 3'b001,
        DVDP_RUN  = 3'b010,
        DVDP_DONE = 3'b100
    } dvdp_state_e;
endpackage : dvdp_pkg

/* rtl/dvdp_poll_timer.sv */
// module: self-polling ON/OFF timer clocked by the RC oscillator enable
module dvdp_poll_timer (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        run,
    input  wire logic        rc_tick,
    input  wire logic [15:0] on_value,
    input  wire logic [15:0] off_value,
    output logic             on_phase,
    output logic             phase_end
);
    logic [15:0] cnt_r;
    logic        on_r;
    logic        started_r;
    logic        end_r;

    wire         wrap    = rc_tick && (cnt_r == dvdp_pkg::TIMER_TOP);
    wire  [15:0] reload  = on_r ? off_value : on_value;

    // =====================================================================
    // counter: load, count up, switch phase on overflow
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r     <= 16'h0000;
            on_r      <= 1'b0;
            started_r <= 1'b0;
            end_r     <= 1'b0;
        end else if (!run) begin
            started_r <= 1'b0;
            on_r      <= 1'b0;
            end_r     <= 1'b0;
        end else if (!started_r) begin
            cnt_r     <= on_value;
            on_r      <= 1'b1;
            started_r <= 1'b1;
            end_r     <= 1'b0;
        end else if (wrap) begin
            cnt_r     <= reload;
            on_r      <= !on_r;
            end_r     <= 1'b1;
        end else begin
            if (rc_tick) begin
                cnt_r <= cnt_r + 16'h0001;
            end
            end_r     <= 1'b0;
        end
    end

    assign on_phase  = on_r;
    assign phase_end = end_r;
endmodule : dvdp_poll_timer

/* rtl/dvdp_top.sv */
// module: data valid detection, self polling and peak detector sequencing behind APB
module dvdp_top #(
    parameter int SEQ_DELAY = dvdp_pkg::SEQ_DELAY_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rx_path_active,
    input  wire logic        sliced_data,
    input  wire logic [5:0]  strength_code,
    output logic             rx_enable,
    output logic             pkd_enable,
    output logic             pkd_pos_to_gnd,
    output logic             pkd_neg_to_vcc,
    output logic             data_valid,
    output logic             wake_indication_pulse
);
    // =====================================================================
    // registers
    logic [7:0]  config_r;
    logic [15:0] polling_on_duration_r;
    logic [15:0] polling_off_duration_r;
    logic [11:0] rate_window_lower_r;
    logic [11:0] rate_window_upper_r;
    logic [5:0]  strength_threshold_r;
    logic        pready_r;
    logic        pslverr_r;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;

    // =====================================================================
    // apb decode
    wire         word_ok   = (paddr[1:0] == 2'b00);
    wire  [3:0]  idx       = paddr[5:2];
    wire         in_range  = word_ok && (paddr[7:6] == 2'b00);
    wire         hit_cfg   = in_range && (idx == dvdp_pkg::IDX_CONFIG);
    wire         hit_on    = in_range && (idx == dvdp_pkg::IDX_ON_DUR);
    wire         hit_off   = in_range && (idx == dvdp_pkg::IDX_OFF_DUR);
    wire         hit_lo    = in_range && (idx == dvdp_pkg::IDX_WIN_LOWER);
    wire         hit_hi    = in_range && (idx == dvdp_pkg::IDX_WIN_UPPER);
    wire         hit_th    = in_range && (idx == dvdp_pkg::IDX_STRENGTH);
    wire         hit_st    = in_range && (idx == dvdp_pkg::IDX_STATUS);
    wire         mapped    = hit_cfg | hit_on | hit_off | hit_lo | hit_hi | hit_th | hit_st;
    wire         access    = psel && penable && !pready_r;
    wire         commit    = psel && penable && pready_r;
    wire         wr_ok     = commit && pwrite && !pslverr_r;

    wire         cfg_rx_en   = config_r[dvdp_pkg::CFG_RX_EN_BIT];
    wire         cfg_poll_en = config_r[dvdp_pkg::CFG_POLL_EN_BIT];
    wire         cfg_cont    = config_r[dvdp_pkg::CFG_CONT_BIT];
    wire         cfg_single  = config_r[dvdp_pkg::CFG_SINGLE_BIT];
    wire         rearm       = wr_ok && hit_cfg;

    // =====================================================================
    // status word
    logic        det_enable_r;
    logic        rate_lat_r;
    logic        strength_lat_r;
    logic        on_phase;
    wire  [31:0] status_word = {25'h0, pkd_enable, data_valid, on_phase, rx_enable,
                                det_enable_r, strength_lat_r, rate_lat_r};

    always_comb begin
        prdata_nxt = 32'h00000000;
        unique case (1'b1)
            hit_cfg: prdata_nxt = {24'h000000, config_r};
            hit_on:  prdata_nxt = {16'h0000, polling_on_duration_r};
            hit_off: prdata_nxt = {16'h0000, polling_off_duration_r};
            hit_lo:  prdata_nxt = {20'h00000, rate_window_lower_r};
            hit_hi:  prdata_nxt = {20'h00000, rate_window_upper_r};
            hit_th:  prdata_nxt = {26'h0000000, strength_threshold_r};
            hit_st:  prdata_nxt = status_word;
            default: prdata_nxt = 32'h00000000;
        endcase
    end

    // =====================================================================
    // apb slave: one wait state, answer registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h00000000;
        end else begin
            pready_r  <= access;
            pslverr_r <= access && !mapped;
            if (access && !pwrite) begin
                prdata_r <= prdata_nxt;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            config_r               <= dvdp_pkg::CFG_RST;
            polling_on_duration_r  <= dvdp_pkg::ON_DUR_RST;
            polling_off_duration_r <= dvdp_pkg::OFF_DUR_RST;
            rate_window_lower_r    <= dvdp_pkg::WIN_LOWER_RST;
            rate_window_upper_r    <= dvdp_pkg::WIN_UPPER_RST;
            strength_threshold_r   <= dvdp_pkg::STRENGTH_RST;
        end else if (wr_ok) begin
            if (hit_cfg) config_r               <= pwdata[7:0];
            if (hit_on)  polling_on_duration_r  <= pwdata[15:0];
            if (hit_off) polling_off_duration_r <= pwdata[15:0];
            if (hit_lo)  rate_window_lower_r    <= pwdata[11:0];
            if (hit_hi)  rate_window_upper_r    <= pwdata[11:0];
            if (hit_th)  strength_threshold_r   <= pwdata[5:0];
        end
    end

    assign pready  = pready_r;
    assign pslverr = pslverr_r;
    assign prdata  = prdata_r;

    // =====================================================================
    // rate dividers: quarter clock for the window, rc tick for polling
    logic [1:0]  qdiv_r;
    logic [8:0]  rcdiv_r;
    wire         win_tick = (qdiv_r == 2'(dvdp_pkg::WIN_DIV - 1));
    wire         rc_tick  = (rcdiv_r == 9'(dvdp_pkg::RC_DIV - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            qdiv_r  <= 2'b00;
            rcdiv_r <= 9'h000;
        end else begin
            qdiv_r  <= qdiv_r + 2'b01;
            rcdiv_r <= rc_tick ? 9'h000 : rcdiv_r + 9'h001;
        end
    end

    // =====================================================================
    // self polling timer
    logic        phase_end;
    wire         polling = cfg_poll_en && !cfg_rx_en;

    dvdp_poll_timer u_timer (
        .pclk      (pclk),
        .presetn   (presetn),
        .run       (polling),
        .rc_tick   (rc_tick),
        .on_value  (polling_on_duration_r),
        .off_value (polling_off_duration_r),
        .on_phase  (on_phase),
        .phase_end (phase_end)
    );

    wire         rx_on_nxt = cfg_rx_en || (polling && on_phase);

    // =====================================================================
    // sequencer: delay from receive on to detection enable
    logic [15:0] seq_cnt_r;
    logic        rx_on_r;
    wire         seq_done = (seq_cnt_r == 16'(SEQ_DELAY - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq_cnt_r    <= 16'h0000;
            det_enable_r <= 1'b0;
            rx_on_r      <= 1'b0;
        end else begin
            rx_on_r <= rx_on_nxt;
            if (!rx_on_nxt) begin
                seq_cnt_r    <= 16'h0000;
                det_enable_r <= 1'b0;
            end else if (!det_enable_r) begin
                seq_cnt_r    <= seq_cnt_r + 16'h0001;
                det_enable_r <= seq_done;
            end
        end
    end

    // peak detector off until the whole path runs; clamps applied while off
    logic        pkd_en_r;
    wire         pkd_en_nxt = rx_on_nxt && rx_path_active && det_enable_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pkd_en_r <= 1'b0;
        end else begin
            pkd_en_r <= pkd_en_nxt;
        end
    end

    assign rx_enable      = rx_on_r;
    assign pkd_enable     = pkd_en_r;
    assign pkd_pos_to_gnd = !pkd_en_r;
    assign pkd_neg_to_vcc = !pkd_en_r;

    // =====================================================================
    // window counter on the high phase of sliced data
    logic        data_q_r;
    logic [12:0] win_cnt_r;
    logic        high_seen_r;
    wire         rise     = sliced_data && !data_q_r;
    wire         fall     = !sliced_data && data_q_r;
    // default limit pair 0/1 keeps the counter out of use
    wire         win_idle = (rate_window_lower_r == dvdp_pkg::WIN_LOWER_RST) &&
                            (rate_window_upper_r == dvdp_pkg::WIN_UPPER_RST);
    wire  [12:0] lo1      = {1'b0, rate_window_lower_r};
    wire  [12:0] hi1      = {1'b0, rate_window_upper_r};
    wire  [12:0] lo2      = {rate_window_lower_r, 1'b0};
    wire  [12:0] hi2      = {rate_window_upper_r, 1'b0};
    wire         m_single = (win_cnt_r >= lo1) && (win_cnt_r <= hi1);
    wire         m_double = (win_cnt_r >= lo2) && (win_cnt_r <= hi2);
    wire         match    = m_single || m_double;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_q_r    <= 1'b0;
            win_cnt_r   <= 13'h0000;
            high_seen_r <= 1'b0;
        end else begin
            data_q_r <= sliced_data;
            if (!det_enable_r || win_idle) begin
                win_cnt_r   <= 13'h0000;
                high_seen_r <= 1'b0;
            end else if (rise) begin
                win_cnt_r   <= 13'h0000;
                high_seen_r <= 1'b1;
            end else if (sliced_data && win_tick && (win_cnt_r != 13'h1FFF)) begin
                win_cnt_r   <= win_cnt_r + 13'h0001;
            end
        end
    end

    // =====================================================================
    // conversion control
    dvdp_pkg::dvdp_state_e state_r;
    dvdp_pkg::dvdp_state_e state_nxt;
    logic [1:0]  per_cnt_r;
    logic        all_ok_r;
    logic        done_r;
    wire         period_end = fall && high_seen_r && (state_r == dvdp_pkg::DVDP_RUN);
    wire         last       = (per_cnt_r == 2'(dvdp_pkg::CONV_PERIODS - 1));
    wire         complete   = period_end && last;
    wire         mode_on    = cfg_cont || cfg_single;
    // strength limit of all ones reads as detection off
    wire         strength_ok = (strength_threshold_r != dvdp_pkg::STRENGTH_RST) &&
                               (strength_code >= strength_threshold_r);

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            dvdp_pkg::DVDP_IDLE: begin
                if (det_enable_r && !win_idle && mode_on) state_nxt = dvdp_pkg::DVDP_RUN;
            end
            dvdp_pkg::DVDP_RUN: begin
                if (!det_enable_r || win_idle || !mode_on) begin
                    state_nxt = dvdp_pkg::DVDP_IDLE;
                end else if (complete && !cfg_cont) begin
                    state_nxt = dvdp_pkg::DVDP_DONE;
                end
            end
            dvdp_pkg::DVDP_DONE: begin
                if (!det_enable_r || rearm) state_nxt = dvdp_pkg::DVDP_IDLE;
            end
            default: state_nxt = dvdp_pkg::DVDP_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r   <= dvdp_pkg::DVDP_IDLE;
            per_cnt_r <= 2'b00;
            all_ok_r  <= 1'b1;
            done_r    <= 1'b0;
        end else begin
            state_r <= state_nxt;
            done_r  <= complete;
            if (state_r != dvdp_pkg::DVDP_RUN || complete) begin
                per_cnt_r <= 2'b00;
                all_ok_r  <= 1'b1;
            end else if (period_end) begin
                per_cnt_r <= per_cnt_r + 2'b01;
                all_ok_r  <= all_ok_r && match;
            end
        end
    end

    // =====================================================================
    // latched results and outputs
    logic        valid_r;
    logic        wake_r;
    wire         valid_nxt = strength_lat_r && rate_lat_r && det_enable_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rate_lat_r     <= 1'b0;
            strength_lat_r <= 1'b0;
            valid_r        <= 1'b0;
            wake_r         <= 1'b0;
        end else begin
            if (!det_enable_r) begin
                rate_lat_r     <= 1'b0;
                strength_lat_r <= 1'b0;
            end else if (complete) begin
                rate_lat_r     <= all_ok_r && match;
                strength_lat_r <= strength_ok;
            end
            valid_r <= valid_nxt;
            // only a fresh valid inside an on phase wakes the controller
            wake_r  <= valid_nxt && !valid_r && polling && on_phase && !phase_end;
        end
    end

    assign data_valid            = valid_r;
    assign wake_indication_pulse = wake_r;
endmodule : dvdp_top

/* verif/dvdp_checker.sv */
// checker: port timing relations of the data valid detect block
module dvdp_checker #(
    parameter int SEQ_DELAY = 20
) (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic [7:0] paddr,
    input wire logic       pready,
    input wire logic       pslverr,
    input wire logic       rx_path_active,
    input wire logic       sliced_data,
    input wire logic       rx_enable,
    input wire logic       pkd_enable,
    input wire logic       pkd_pos_to_gnd,
    input wire logic       pkd_neg_to_vcc,
    input wire logic       data_valid,
    input wire logic       wake_indication_pulse
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // =====================================================
    // bus
    sequence s_acc;
        psel && penable && !pready;
    endsequence
    property p_ready_next;
        s_acc |=> pready;
    endproperty
    a_ready_next: assert property (p_ready_next) else $error("pready late");
    property p_bad_addr;
        pready && psel && (paddr[1:0] != 2'h0 || paddr[7:6] != 2'h0
            || !(paddr[5:2] inside {4'h0, [4'h4:4'h9]})) |-> pslverr;
    endproperty
    a_bad_addr: assert property (p_bad_addr) else $error("unmapped not refused");
    // =====================================================
    // peak detector
    property p_clamp;
        pkd_pos_to_gnd == !pkd_enable && pkd_neg_to_vcc == !pkd_enable;
    endproperty
    a_clamp: assert property (p_clamp) else $error("peak clamp wrong");
    property p_path;
        !rx_path_active |=> !pkd_enable;
    endproperty
    a_path: assert property (p_path) else $error("peak on without path");
    property p_rxoff;
        !rx_enable |=> !pkd_enable;
    endproperty
    a_rxoff: assert property (p_rxoff) else $error("peak on without receive");
    // detection must stay off for a while after receive starts
    sequence s_rx_on;
        $rose(rx_enable);
    endsequence
    property p_det_wait;
        s_rx_on |-> !pkd_enable [*8];
    endproperty
    a_det_wait: assert property (p_det_wait) else $error("detect enable early");
    // =====================================================
    // valid and wake
    property p_valid_fall;
        $rose(data_valid) |-> !$past(sliced_data, 2);
    endproperty
    a_valid_fall: assert property (p_valid_fall) else $error("valid not after fall");
    property p_wake_once;
        wake_indication_pulse |=> !wake_indication_pulse;
    endproperty
    a_wake_once: assert property (p_wake_once) else $error("wake too long");
    property p_wake_cause;
        wake_indication_pulse |-> data_valid && !$past(data_valid);
    endproperty
    a_wake_cause: assert property (p_wake_cause) else $error("wake without valid");
endmodule : dvdp_checker

/* verif/dvdp_mcu_model.sv */
// partner: microcontroller counting the wake pulses it receives
module dvdp_mcu_model (
    input wire logic wake_indication_pulse,
    input wire logic pclk,
    input wire logic presetn,
    output int       wakes
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wakes <= 0;
        end else if (wake_indication_pulse) begin
            wakes <= wakes + 1;
        end
    end
endmodule : dvdp_mcu_model

/* verif/test_dvdp_top.sv */
// testbench: registers, detection, peak sequencing and self polling
module test_dvdp_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int SEQ = 20;
    logic        pclk = 0;
    logic        presetn = 0;
    logic        psel = 0;
    logic        penable = 0;
    logic        pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        rx_path_active = 1;
    logic        sliced_data = 0;
    logic [5:0]  strength_code = 6'h14;
    logic [31:0] prdata, q;
    logic        pready, pslverr, rx_enable, pkd_enable, pkd_pos_to_gnd, pkd_neg_to_vcc;
    logic        data_valid, wake_indication_pulse, e;
    int          errors = 0;
    int          total_checks = 0;
    int          wakes;
    always #50 pclk = ~pclk;
    dvdp_top #(.SEQ_DELAY(SEQ)) uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .rx_path_active, .sliced_data, .strength_code, .rx_enable, .pkd_enable,
        .pkd_pos_to_gnd, .pkd_neg_to_vcc, .data_valid, .wake_indication_pulse);
    dvdp_mcu_model mcu (.pclk, .presetn, .wake_indication_pulse, .wakes);
    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // request held up to the edge that samples pready high; read data taken at that edge
    task automatic apb(input logic wr, input logic [3:0] idx, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        if (pready !== 1'b1) begin
            chk("pready", 32'h1, 32'(pready));
            final_report();
        end
        q = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb
    function automatic logic pick(input int k);
        return k == 0 ? pkd_enable : rx_enable;
    endfunction : pick
    task automatic wait_on(input int k, input logic v, input int lim);
        int n;
        n = 0;
        while (pick(k) !== v && n < lim) begin
            @(negedge pclk);
            n++;
        end
        chk("wait level", 32'(v), 32'(pick(k)));
        if (pick(k) !== v) final_report();
    endtask : wait_on
    // six periods, so conversions of three periods line up with each burst
    task automatic send(input int hi);
        repeat (6) begin
            @(posedge pclk);
            sliced_data <= 1;
            repeat (hi) @(posedge pclk);
            sliced_data <= 0;
            repeat (31) @(posedge pclk);
        end
        repeat (8) @(negedge pclk);
    endtask : send
    task automatic t_regs;
        logic [31:0] rv [5] = '{32'hFEBF, 32'hF37F, 32'h0, 32'h1, 32'h3F};
        logic [31:0] mk [5] = '{32'hFFFF, 32'hFFFF, 32'hFFF, 32'hFFF, 32'h3F};
        chk("clamps", 32'h3, 32'({pkd_pos_to_gnd, pkd_neg_to_vcc}));
        apb(0, 4'h9, 32'h0);
        chk("status reset", 32'h0, q);
        for (int i = 0; i < 5; i++) begin
            apb(0, 4'(i + 4), 32'h0);
            chk("reset value", rv[i], q);
            apb(1, 4'(i + 4), 32'hFFFFFFFF);
            apb(0, 4'(i + 4), 32'h0);
            chk("field width", mk[i], q);
        end
        apb(0, 4'hC, 32'h0);
        chk("unmapped error", 32'h1, 32'(e));
        $display("test registers done");
    endtask : t_regs
    task automatic t_detect;
        int hi [5] = '{32, 200, 64, 32, 32};
        logic [5:0] sc [5] = '{6'h14, 6'h14, 6'h14, 6'h09, 6'h0A};
        logic dv [5] = '{1, 0, 1, 0, 1};
        apb(1, 4'h6, 32'h4);
        apb(1, 4'h7, 32'hC);
        apb(1, 4'h8, 32'hA);
        apb(1, 4'h0, 32'h21);
        chk("peak early", 32'h0, 32'(pkd_enable));
        wait_on(0, 1, SEQ + 20);
        chk("clamps off", 32'h0, 32'({pkd_pos_to_gnd, pkd_neg_to_vcc}));
        apb(0, 4'h9, 32'h0);
        chk("status running", 32'h4C, q);
        for (int i = 0; i < 5; i++) begin
            @(posedge pclk);
            strength_code <= sc[i];
            send(hi[i]);
            chk("data valid", 32'(dv[i]), 32'(data_valid));
        end
        apb(1, 4'h8, 32'h3F);
        strength_code <= 6'h3F;
        send(32);
        chk("strength inactive", 32'h0, 32'(data_valid));
        @(posedge pclk);
        rx_path_active <= 0;
        wait_on(0, 0, 10);
        @(posedge pclk);
        rx_path_active <= 1;
        apb(1, 4'h8, 32'hA);
        strength_code <= 6'h14;
        apb(1, 4'h0, 32'h41);
        repeat (SEQ + 5) @(posedge pclk);
        wait_on(0, 1, SEQ + 20);
        send(32);
        chk("single shot", 32'h1, 32'(data_valid));
        @(posedge pclk);
        strength_code <= 6'h00;
        send(32);
        chk("single stops", 32'h1, 32'(data_valid));
        apb(1, 4'h0, 32'h21);
        send(32);
        chk("continuous", 32'h0, 32'(data_valid));
        $display("test detection done");
    endtask : t_detect
    task automatic t_poll;
        int n;
        n = 0;
        apb(1, 4'h4, 32'hFFF0);
        apb(1, 4'h5, 32'hFFFF);
        strength_code <= 6'h14;
        apb(1, 4'h0, 32'h22);
        // receive drops while the timer starts; let the old enable clear first
        repeat (4) @(posedge pclk);
        wait_on(1, 1, 6000);
        wait_on(0, 1, SEQ + 20);
        send(32);
        chk("wake count", 32'h1, 32'(wakes));
        wait_on(1, 0, 6000);
        wait_on(1, 1, 1000);
        while (rx_enable === 1'b1 && n < 6000) begin
            @(negedge pclk);
            n++;
        end
        chk("on phase", 32'h1, 32'(n >= 16 * 312 - 3 && n <= 16 * 312 + 3));
        $display("test polling done");
    endtask : t_poll
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1;
        t_regs();
        t_detect();
        t_poll();
        final_report();
    end
endmodule : test_dvdp_top
bind dvdp_top dvdp_checker #(.SEQ_DELAY(SEQ_DELAY)) chk_i (.pclk, .presetn, .psel, .penable, .paddr, .pready,
    .pslverr, .rx_path_active, .sliced_data, .rx_enable, .pkd_enable, .pkd_pos_to_gnd, .pkd_neg_to_vcc,
    .data_valid, .wake_indication_pulse);
